// ---- src/tdmpm_pkg.sv ----
package tdmpm_pkg;

	// synchroniser lanes: link clock, frame, two data pins, three mode pins
	localparam int SYNC_W = 7;
	localparam int MODE_W = 3;

	// frame geometry: 32 slots of 8 bits, msb first on the wire
	localparam int SLOTS = 32;
	localparam int SLOT_BITS = 8;
	localparam logic [7:0] FRAME_LAST = 8'hFF;
	localparam logic [2:0] BYTE_LAST = 3'h7;
	localparam logic [7:0] BIT_STEP = 8'h01;

	// slot numbers
	localparam logic [4:0] SLOT_DUAL_B1 = 5'h00;
	localparam logic [4:0] SLOT_DUAL_B2 = 5'h10;
	localparam logic [4:0] SLOT_CD_FIRST = 5'h00;
	localparam logic [4:0] SLOT_CD_SECOND = 5'h10;
	localparam logic [4:0] SLOT_ONE_D = 5'h00;
	localparam logic [4:0] SLOT_ONE_C = 5'h01;
	localparam logic [4:0] SLOT_ONE_B1 = 5'h02;
	localparam logic [4:0] SLOT_ONE_B2 = 5'h03;
	localparam logic [4:0] CHAIN_DUAL = 5'h01;
	localparam logic [4:0] CHAIN_ONE_80 = 5'h03;
	localparam logic [4:0] CHAIN_ONE_160 = 5'h04;

	// control channel decode
	localparam logic [1:0] SEL_CTRL = 2'h0;
	localparam logic [1:0] SEL_DIAG = 2'h2;
	localparam logic [3:0] DEFAULT_TOP = 4'hF;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] DIAG_RESET = 8'h00;
	localparam logic [7:0] D_MASK_80 = 8'h01;
	localparam logic [7:0] D_MASK_160 = 8'h03;

	// mode select pin codes
	localparam logic [2:0] MODE_OFF = 3'h7;
	localparam logic [2:0] MODE_MODEM_A = 3'h1;
	localparam logic [2:0] MODE_MODEM_B = 3'h5;
	localparam logic [2:0] MODE_ONE_A = 3'h2;
	localparam logic [2:0] MODE_ONE_B = 3'h6;
	localparam logic [2:0] MODE_DFIRST = 3'h3;

	// channel kinds within a slot
	localparam logic [2:0] KIND_NONE = 3'h0;
	localparam logic [2:0] KIND_B1 = 3'h1;
	localparam logic [2:0] KIND_B2 = 3'h2;
	localparam logic [2:0] KIND_C = 3'h3;
	localparam logic [2:0] KIND_D = 3'h4;

	typedef struct packed {
		logic housekeeping;
		logic fastConverge;
		logic scramblerEn;
		logic dInBearer;
		logic lineRate;
		logic diagClear;
		logic [1:0] regSel;
	} tdmpm_ctrl_type;

	typedef struct packed {
		logic network;
		logic onePort;
		logic dFirst;
		logic outOff;
	} tdmpm_mode_type;

	typedef struct packed {
		logic [7:0] b1;
		logic [7:0] b2;
		logic [7:0] d;
	} tdmpm_line_type;

endpackage : tdmpm_pkg

// ---- src/tdmpm_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
module tdmpm_sync #(
	parameter int W = 1
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);

	logic [W-1:0] meta_q;

	// first stage feeds only the second
	always_ff @(posedge clock) begin
		if (!rstn) begin
			// idle-high pins: no false link edge once reset lets go
			meta_q <= '1;
			dout <= '1;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end

endmodule : tdmpm_sync
`default_nettype wire

// ---- src/tdmpm_mapper.sv ----
// Contract
// R1: network port: 32 slots of 8 bits
// R2: dual: C/D on control, B on bearer
// R3: dual 80k: B1 in bearer slot 0 only
// R4: dual 160k: B1 slot 0, B2 slot 16
// R5: single: all channels on bearer port
// R6: single 80k: D0, C1, B1 slot 2
// R7: single 160k: B2 in slot 3
// R8: modem: continuous bit streams, dual only
// R9: outputs driven only in own slots
// R10: chain frame passed to next device
// R11: control port idle in single layout
// R12: C then D sixteen slots apart
// R13: mode pins swap C and D order
// R14: D channel passed only in network mode
// R15: D bits limited by line rate
// R16: D-in-bearer sends whole D in B1
// R17: selector bits route control or diag
// R18: diag cleared at next frame if requested
// R19: control bit 3 picks line rate
// R20: control bit 5 enables scrambler
// R21: control bit 6 fast convergence
// R22: control bit 7 is housekeeping bit
// R23: bits 4-7 all ones: default mode
// R24: mode 7 floats both outputs
// R25: unknown selector byte is ignored
`timescale 1ns/1ns
`default_nettype none
module tdmpm_mapper (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [2:0] modeSel,
	input wire logic linkClock,
	input wire logic framePulseIn,
	input wire logic bearerSerialIn,
	input wire logic ctrlSerialIn,
	output logic bearerSerialOut,
	output logic bearerOe,
	output logic ctrlSerialOut,
	output logic ctrlOe,
	output logic chainedFrameOut,
	input wire tdmpm_pkg::tdmpm_line_type lineIn,
	input wire logic [7:0] statusIn,
	output tdmpm_pkg::tdmpm_line_type lineOut,
	output logic lineOutStrobe,
	output tdmpm_pkg::tdmpm_ctrl_type ctrlWord,
	output logic [7:0] diagWord,
	output logic housekeepingBit
);

	function automatic tdmpm_pkg::tdmpm_mode_type decodeMode(input logic [2:0] m);
		tdmpm_pkg::tdmpm_mode_type r;
		r.outOff = (m == tdmpm_pkg::MODE_OFF);
		r.network = !(m == tdmpm_pkg::MODE_MODEM_A || m == tdmpm_pkg::MODE_MODEM_B);
		r.onePort = (m == tdmpm_pkg::MODE_ONE_A || m == tdmpm_pkg::MODE_ONE_B);
		r.dFirst = (m == tdmpm_pkg::MODE_DFIRST);
		return r;
	endfunction : decodeMode

	// which channel a slot carries on one port
	function automatic logic [2:0] kindOf(
		input tdmpm_pkg::tdmpm_mode_type m,
		input logic rate,
		input logic ctrlPort,
		input logic [4:0] slot
	);
		logic [2:0] k;
		k = tdmpm_pkg::KIND_NONE;
		if (!m.network) begin
			// every bit is payload in modem streams
			k = ctrlPort ? tdmpm_pkg::KIND_C : tdmpm_pkg::KIND_B1; // R8
		end else if (m.onePort) begin
			if (!ctrlPort) begin // R5 R11
				if (slot == tdmpm_pkg::SLOT_ONE_D) begin // R6
					k = tdmpm_pkg::KIND_D;
				end else if (slot == tdmpm_pkg::SLOT_ONE_C) begin
					k = tdmpm_pkg::KIND_C;
				end else if (slot == tdmpm_pkg::SLOT_ONE_B1) begin
					k = tdmpm_pkg::KIND_B1;
				end else if (slot == tdmpm_pkg::SLOT_ONE_B2 && rate) begin // R7
					k = tdmpm_pkg::KIND_B2;
				end
			end
		end else if (ctrlPort) begin // R2 R12
			if (slot == tdmpm_pkg::SLOT_CD_FIRST) begin
				k = m.dFirst ? tdmpm_pkg::KIND_D : tdmpm_pkg::KIND_C; // R13
			end else if (slot == tdmpm_pkg::SLOT_CD_SECOND) begin
				k = m.dFirst ? tdmpm_pkg::KIND_C : tdmpm_pkg::KIND_D; // R13
			end
		end else begin
			if (slot == tdmpm_pkg::SLOT_DUAL_B1) begin // R3
				k = tdmpm_pkg::KIND_B1;
			end else if (slot == tdmpm_pkg::SLOT_DUAL_B2 && rate) begin // R4
				k = tdmpm_pkg::KIND_B2;
			end
		end
		return k;
	endfunction : kindOf

	logic [tdmpm_pkg::SYNC_W-1:0] syncIn;
	logic [tdmpm_pkg::SYNC_W-1:0] syncOut;
	logic linkS;
	logic frameS;
	logic bInS;
	logic cInS;
	logic linkPrev_q;
	logic rise;
	logic fall;
	tdmpm_pkg::tdmpm_mode_type mode_q;
	tdmpm_pkg::tdmpm_ctrl_type ctrl_q;
	logic [7:0] diag_q;
	logic diagPend_q;
	logic [7:0] cnt_q;
	logic [7:0] cur;
	logic [7:0] nIdx;
	logic byteDone;
	logic frameEdge;
	logic xferPoint;
	logic [6:0] bSh_q;
	logic [6:0] cSh_q;
	logic [7:0] bByte;
	logic [7:0] cByte;
	logic [2:0] kB;
	logic [2:0] kC;
	logic [2:0] nB;
	logic [2:0] nC;
	logic [7:0] cmd;
	logic cmdValid;
	logic cmdDefault;
	logic [7:0] dMask;
	tdmpm_pkg::tdmpm_line_type rxHold_q;
	tdmpm_pkg::tdmpm_line_type txHold_q;
	logic [7:0] txStat_q;
	logic bearerDrv_q;
	logic ctrlDrv_q;
	logic [4:0] chainSlot;

	assign syncIn = {modeSel, ctrlSerialIn, bearerSerialIn, framePulseIn, linkClock};

	tdmpm_sync #(
		.W(tdmpm_pkg::SYNC_W)
	) u_sync (
		.clock(clock),
		.rstn(rstn),
		.din(syncIn),
		.dout(syncOut)
	);

	assign linkS = syncOut[0];
	assign frameS = syncOut[1];
	assign bInS = syncOut[2];
	assign cInS = syncOut[3];

	always_ff @(posedge clock) begin
		if (!rstn) begin
			linkPrev_q <= 1'b1;
		end else begin
			linkPrev_q <= linkS;
		end
	end

	// inputs sampled on rising link edges, outputs change on falling
	assign rise = linkS && !linkPrev_q;
	assign fall = !linkS && linkPrev_q;

	always_ff @(posedge clock) begin
		if (!rstn) begin
			mode_q <= '0;
		end else begin
			mode_q <= decodeMode(syncOut[6:4]);
		end
	end

	// bit position in frame; frame pulse marks bit 0
	assign cur = frameS ? 8'h00 : cnt_q + tdmpm_pkg::BIT_STEP; // R1
	assign nIdx = cnt_q + tdmpm_pkg::BIT_STEP;
	assign byteDone = (cur[2:0] == tdmpm_pkg::BYTE_LAST);
	assign frameEdge = rise && frameS;
	// modem streams hand over every byte, network once per frame
	assign xferPoint = rise && (cur == tdmpm_pkg::FRAME_LAST || (!mode_q.network && byteDone)); // R8

	always_ff @(posedge clock) begin
		if (!rstn) begin
			cnt_q <= tdmpm_pkg::FRAME_LAST;
		end else if (rise) begin
			cnt_q <= cur;
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			bSh_q <= '0;
			cSh_q <= '0;
		end else if (rise) begin
			bSh_q <= {bSh_q[5:0], bInS};
			cSh_q <= {cSh_q[5:0], cInS};
		end
	end

	assign bByte = {bSh_q, bInS};
	assign cByte = {cSh_q, cInS};
	assign kB = kindOf(mode_q, ctrl_q.lineRate, 1'b0, cur[7:3]);
	assign kC = kindOf(mode_q, ctrl_q.lineRate, 1'b1, cur[7:3]);
	assign dMask = ctrl_q.lineRate ? tdmpm_pkg::D_MASK_160 : tdmpm_pkg::D_MASK_80; // R15

	// control byte arrives on bearer port in single layout
	assign cmd = (kB == tdmpm_pkg::KIND_C) ? bByte : cByte;
	assign cmdValid = rise && byteDone && mode_q.network
		&& (kB == tdmpm_pkg::KIND_C || kC == tdmpm_pkg::KIND_C);
	assign cmdDefault = (cmd[7:4] == tdmpm_pkg::DEFAULT_TOP);

	always_ff @(posedge clock) begin
		if (!rstn) begin
			ctrl_q <= tdmpm_pkg::CTRL_RESET;
		end else if (cmdValid && cmd[1:0] == tdmpm_pkg::SEL_CTRL) begin // R17
			if (cmdDefault) begin
				// features off, housekeeping zero, rate from bit 3
				ctrl_q <= '0; // R23
				ctrl_q.lineRate <= cmd[3]; // R23
			end else begin
				ctrl_q <= cmd; // R19 R20 R21 R22
			end
		end
	end

	// a new request wins over the clear by the frame edge
	always_ff @(posedge clock) begin
		if (!rstn) begin
			diagPend_q <= 1'b0;
		end else if (cmdValid && cmd[1:0] == tdmpm_pkg::SEL_CTRL && !cmdDefault && !cmd[2]) begin
			diagPend_q <= 1'b1; // R18
		end else if (frameEdge) begin
			diagPend_q <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			diag_q <= tdmpm_pkg::DIAG_RESET;
		end else if (frameEdge && diagPend_q) begin
			diag_q <= tdmpm_pkg::DIAG_RESET; // R18
		end else if (cmdValid && cmd[1:0] == tdmpm_pkg::SEL_CTRL && cmdDefault) begin
			diag_q <= tdmpm_pkg::DIAG_RESET; // R23
		end else if (cmdValid && cmd[1:0] == tdmpm_pkg::SEL_DIAG) begin
			diag_q <= cmd; // R17
		end
		// other selector codes fall through untouched R25
	end

	// collect system bytes for the line
	always_ff @(posedge clock) begin
		if (!rstn) begin
			rxHold_q <= '0;
		end else if (rise && byteDone && mode_q.network) begin
			if (kB == tdmpm_pkg::KIND_B1) begin
				rxHold_q.b1 <= bByte;
			end else if (kB == tdmpm_pkg::KIND_B2) begin
				rxHold_q.b2 <= bByte;
			end else if (kB == tdmpm_pkg::KIND_D) begin
				rxHold_q.d <= bByte;
			end
			if (kC == tdmpm_pkg::KIND_D) begin
				rxHold_q.d <= cByte;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			lineOut <= '0;
		end else if (xferPoint) begin
			if (!mode_q.network) begin
				lineOut <= '0; // R14
				lineOut.b1 <= bByte; // R8
			end else if (ctrl_q.dInBearer) begin
				lineOut.b1 <= rxHold_q.d; // R16
				lineOut.b2 <= ctrl_q.lineRate ? rxHold_q.b2 : 8'h00;
				lineOut.d <= 8'h00;
			end else begin
				lineOut.b1 <= rxHold_q.b1;
				lineOut.b2 <= ctrl_q.lineRate ? rxHold_q.b2 : 8'h00;
				lineOut.d <= rxHold_q.d & dMask; // R15
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			lineOutStrobe <= 1'b0;
		end else begin
			lineOutStrobe <= xferPoint;
		end
	end

	// line bytes latched just before the first bit they feed
	always_ff @(posedge clock) begin
		if (!rstn) begin
			txHold_q <= '0;
			txStat_q <= '0;
		end else if (xferPoint) begin
			txStat_q <= statusIn;
			txHold_q.b2 <= lineIn.b2;
			if (!mode_q.network) begin
				txHold_q.b1 <= lineIn.b1;
				txHold_q.d <= 8'h00; // R14
			end else if (ctrl_q.dInBearer) begin
				txHold_q.b1 <= 8'h00;
				txHold_q.d <= lineIn.b1; // R16
			end else begin
				txHold_q.b1 <= lineIn.b1;
				txHold_q.d <= lineIn.d & dMask; // R15
			end
		end
	end

	function automatic logic pickBit(
		input logic [2:0] k,
		input tdmpm_pkg::tdmpm_line_type h,
		input logic [7:0] st,
		input logic [2:0] pos
	);
		logic [7:0] b;
		b = 8'h00;
		if (k == tdmpm_pkg::KIND_B1) begin
			b = h.b1;
		end else if (k == tdmpm_pkg::KIND_B2) begin
			b = h.b2;
		end else if (k == tdmpm_pkg::KIND_D) begin
			b = h.d;
		end else if (k == tdmpm_pkg::KIND_C) begin
			b = st;
		end
		return b[pos];
	endfunction : pickBit

	assign nB = kindOf(mode_q, ctrl_q.lineRate, 1'b0, nIdx[7:3]);
	assign nC = kindOf(mode_q, ctrl_q.lineRate, 1'b1, nIdx[7:3]);

	always_ff @(posedge clock) begin
		if (!rstn) begin
			bearerSerialOut <= 1'b0;
			bearerDrv_q <= 1'b0;
		end else if (fall) begin
			bearerSerialOut <= pickBit(nB, txHold_q, txStat_q, 3'h7 - nIdx[2:0]);
			bearerDrv_q <= (nB != tdmpm_pkg::KIND_NONE); // R9
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			ctrlSerialOut <= 1'b0;
			ctrlDrv_q <= 1'b0;
		end else if (fall) begin
			ctrlSerialOut <= pickBit(nC, txHold_q, txStat_q, 3'h7 - nIdx[2:0]);
			ctrlDrv_q <= (nC != tdmpm_pkg::KIND_NONE); // R9 R11
		end
	end

	// enables drop at once on mode 7 so a chain never fights at power-up
	assign bearerOe = bearerDrv_q && !mode_q.outOff; // R24
	assign ctrlOe = ctrlDrv_q && !mode_q.outOff && !mode_q.onePort; // R24 R11

	assign chainSlot = !mode_q.onePort ? tdmpm_pkg::CHAIN_DUAL
		: (ctrl_q.lineRate ? tdmpm_pkg::CHAIN_ONE_160 : tdmpm_pkg::CHAIN_ONE_80);

	// next device's slot 0 starts right after our slot 0 in dual layout, right after our last slot in single layout
	always_ff @(posedge clock) begin
		if (!rstn) begin
			chainedFrameOut <= 1'b0;
		end else if (!mode_q.network) begin
			chainedFrameOut <= frameS; // R10
		end else if (fall) begin
			chainedFrameOut <= (nIdx == {chainSlot, 3'h0}); // R10
		end
	end

	assign ctrlWord = ctrl_q;
	assign diagWord = diag_q;
	assign housekeepingBit = ctrl_q.housekeeping; // R22

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);

	a_off_float: assert property (mode_q.outOff |-> !bearerOe && !ctrlOe) // R24
		else $error("outputs driven in mode 7");
	a_single_ctrl: assert property (mode_q.onePort |-> !ctrlOe) // R11
		else $error("control port driven in single layout");
	a_ctrl_write: assert property (cmdValid && cmd[1:0] == tdmpm_pkg::SEL_CTRL && !cmdDefault
		|=> ctrl_q == $past(cmd)) // R17
		else $error("control word not stored");
	a_diag_write: assert property (cmdValid && cmd[1:0] == tdmpm_pkg::SEL_DIAG
		|=> diag_q == $past(cmd)) // R17
		else $error("diag word not stored");
	a_bad_select: assert property (cmdValid && cmd[0] && !frameEdge
		|=> $stable(ctrl_q) && $stable(diag_q)) // R25
		else $error("unknown selector changed a register");
	a_default_mode: assert property (cmdValid && cmd[1:0] == tdmpm_pkg::SEL_CTRL && cmdDefault
		|=> ctrl_q.lineRate == $past(cmd[3]) && !ctrl_q.housekeeping && !ctrl_q.dInBearer && diag_q == 8'h00) // R23
		else $error("default mode not entered");
	a_diag_clear: assert property (frameEdge && diagPend_q |=> diag_q == tdmpm_pkg::DIAG_RESET && !diagPend_q) // R18
		else $error("diag not cleared at frame");
	a_d_bits: assert property (lineOutStrobe && mode_q.network && !ctrl_q.dInBearer
		|-> (lineOut.d & ~dMask) == 8'h00) // R15
		else $error("excess D bits toward line");
	a_modem_d: assert property (lineOutStrobe && !mode_q.network |-> lineOut.d == 8'h00 && lineOut.b2 == 8'h00) // R14
		else $error("D or B2 present in modem mode");
	a_hk_follow: assert property (housekeepingBit == ctrl_q.housekeeping ##1 housekeepingBit == ctrlWord[7]) // R22
		else $error("housekeeping bit mismatch");

	c_ctrl_write: cover property (cmdValid && cmd[1:0] == tdmpm_pkg::SEL_CTRL);
	c_single_drive: cover property (mode_q.onePort && bearerOe);
	c_modem_byte: cover property (!mode_q.network && lineOutStrobe);
	c_chain: cover property (mode_q.network && chainedFrameOut);

endmodule : tdmpm_mapper
`default_nettype wire

// ---- test/tdmpm_bus_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module tdmpm_bus_model (
	output logic linkClock,
	output logic framePulseIn,
	output logic bearerSerialIn,
	output logic ctrlSerialIn,
	input wire logic bearerSerialOut,
	input wire logic bearerOe,
	input wire logic ctrlSerialOut,
	input wire logic ctrlOe,
	input wire logic chainedFrameOut
);
	logic [7:0] txB [32];
	logic [7:0] txC [32];
	logic [7:0] rxB [32];
	logic [7:0] rxC [32];
	logic [255:0] oeBv;
	logic [255:0] oeCv;
	int chainAt;
	initial begin
		linkClock = 1'b1;
		framePulseIn = 1'b0;
		bearerSerialIn = 1'b1;
		ctrlSerialIn = 1'b1;
	end
	// link clock stands high between frames; bits change on the falling edge
	task automatic runBits(input int n, input bit modem);
		int s;
		int b;
		chainAt = -1;
		#1;
		for (int i = 0; i < n; i++) begin
			s = i / 8;
			b = 7 - i % 8;
			linkClock = 1'b0;
			framePulseIn = modem ? (b == 7) : (i == 0);
			bearerSerialIn = txB[s][b];
			ctrlSerialIn = txC[s][b];
			#80;
			oeBv[i] = bearerOe;
			oeCv[i] = ctrlOe;
			rxB[s][b] = bearerSerialOut;
			rxC[s][b] = ctrlSerialOut;
			if (chainedFrameOut === 1'b1 && chainAt < 0) begin
				chainAt = i;
			end
			linkClock = 1'b1;
			#80;
		end
		framePulseIn = 1'b0;
		// released data lines must not keep showing the last bit
		bearerSerialIn = ~bearerSerialIn;
		ctrlSerialIn = ~ctrlSerialIn;
	endtask : runBits
endmodule : tdmpm_bus_model
`default_nettype wire

// ---- test/tdm_port_channel_mapper_test.sv ----
`timescale 1ns/1ns
`default_nettype none
module tdm_port_channel_mapper_test;
	typedef struct {
		logic [2:0] mode;
		logic [7:0] cByte;
		logic [31:0] oeB;
		logic [31:0] oeC;
		int chain;
		logic [7:0] ctrl;
		logic [7:0] diag;
		logic [7:0] lineD;
	} tdmpm_row_type;
	logic clock;
	logic rstn;
	logic [2:0] modeSel;
	logic linkClock, framePulseIn, bearerSerialIn, ctrlSerialIn;
	logic bearerSerialOut, bearerOe, ctrlSerialOut, ctrlOe, chainedFrameOut;
	tdmpm_pkg::tdmpm_line_type lineIn;
	tdmpm_pkg::tdmpm_line_type lineOut;
	logic [7:0] statusIn;
	logic lineOutStrobe;
	tdmpm_pkg::tdmpm_ctrl_type ctrlWord;
	logic [7:0] diagWord;
	logic housekeepingBit;
	int fails = 0;
	int checked = 0;
	int cSlot, dSlot;
	logic single;
	tdmpm_row_type rows [7];
	tdmpm_mapper u_dut (.clock(clock), .rstn(rstn), .modeSel(modeSel), .linkClock(linkClock),
		.framePulseIn(framePulseIn), .bearerSerialIn(bearerSerialIn), .ctrlSerialIn(ctrlSerialIn),
		.bearerSerialOut(bearerSerialOut), .bearerOe(bearerOe), .ctrlSerialOut(ctrlSerialOut), .ctrlOe(ctrlOe),
		.chainedFrameOut(chainedFrameOut), .lineIn(lineIn), .statusIn(statusIn), .lineOut(lineOut),
		.lineOutStrobe(lineOutStrobe), .ctrlWord(ctrlWord), .diagWord(diagWord), .housekeepingBit(housekeepingBit));
	tdmpm_bus_model u_bus (.linkClock(linkClock), .framePulseIn(framePulseIn), .bearerSerialIn(bearerSerialIn),
		.ctrlSerialIn(ctrlSerialIn), .bearerSerialOut(bearerSerialOut), .bearerOe(bearerOe),
		.ctrlSerialOut(ctrlSerialOut), .ctrlOe(ctrlOe), .chainedFrameOut(chainedFrameOut));
	always #2 clock = ~clock;
	task automatic check(input string name, input logic [255:0] seen, input logic [255:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	function automatic logic [255:0] spread(input logic [31:0] m);
		logic [255:0] r;
		for (int i = 0; i < 256; i++) begin
			r[i] = m[i / 8];
		end
		return r;
	endfunction : spread
	task automatic end_sim;
		if (fails == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_sim
	// one frame per row; control byte placed where the mode expects the C slot
	task automatic frame(input logic [2:0] mode, input logic [7:0] cByte);
		@(posedge clock);
		modeSel <= mode;
		repeat (4) @(posedge clock);
		single = (mode == 3'h2) || (mode == 3'h6);
		cSlot = (mode == 3'h3) ? 16 : (single ? 1 : 0);
		dSlot = (mode == 3'h3 || single) ? 0 : 16;
		for (int s = 0; s < 32; s++) begin
			u_bus.txB[s] = 8'hA5;
			u_bus.txC[s] = 8'hA5;
		end
		if (single) begin
			u_bus.txB[cSlot] = cByte;
			u_bus.txB[dSlot] = 8'hFF;
		end else begin
			u_bus.txC[cSlot] = cByte;
			u_bus.txC[dSlot] = 8'hFF;
		end
		u_bus.runBits(256, 1'b0);
		repeat (4) @(posedge clock);
	endtask : frame
	initial begin
		#380000;
		fails++;
		end_sim();
	end
	initial begin
		clock = 1'b0;
		rstn = 1'b0;
		modeSel = 3'h0;
		lineIn = 24'h3C3C3C;
		statusIn = 8'h5A;
		rows = '{
			'{3'h0, 8'h04, 32'h00000001, 32'h00010001, 8, 8'h04, 8'h00, 8'h01},
			'{3'h2, 8'h01, 32'h00000007, 32'h00000000, 24, 8'h04, 8'h00, 8'h01},
			'{3'h4, 8'h8C, 32'h00010001, 32'h00010001, 8, 8'h8C, 8'h00, 8'h03},
			'{3'h3, 8'h0D, 32'h00010001, 32'h00010001, 8, 8'h8C, 8'h00, 8'h03},
			'{3'h6, 8'h0E, 32'h0000000F, 32'h00000000, 32, 8'h8C, 8'h0E, 8'h03},
			'{3'h7, 8'h01, 32'h00000000, 32'h00000000, -1, 8'h8C, 8'h0E, 8'h00},
			'{3'h0, 8'h68, 32'h00010001, 32'h00010001, 8, 8'h68, 8'h0E, 8'h03}};
		repeat (5) @(posedge clock);
		check("reset ctrl", ctrlWord, 8'h00);
		check("reset oe", {bearerOe, ctrlOe, diagWord}, 10'h000);
		rstn <= 1'b1;
		for (int r = 0; r < 7; r++) begin
			frame(rows[r].mode, rows[r].cByte);
			check("bearer oe", u_bus.oeBv, spread(rows[r].oeB));
			check("ctrl oe", u_bus.oeCv, spread(rows[r].oeC));
			check("ctrl word", ctrlWord, rows[r].ctrl);
			check("housekeeping", housekeepingBit, rows[r].ctrl[7]);
			check("diag word", diagWord, rows[r].diag);
			if (rows[r].chain >= 0) begin
				check("chain bit", u_bus.chainAt, rows[r].chain);
				check("line d", lineOut.d, rows[r].lineD);
				check("line b1", lineOut.b1, 8'hA5);
			end
			if (r > 0 && rows[r].chain >= 0) begin
				check("status byte", single ? u_bus.rxB[cSlot] : u_bus.rxC[cSlot], 8'h5A);
				check("b1 out", u_bus.rxB[single ? 2 : 0], 8'h3C);
			end
		end
		// diag clear requested last frame lands at this frame's pulse
		frame(3'h0, 8'hF8);
		check("diag cleared", diagWord, 8'h00);
		check("default mode", ctrlWord[7:3], 5'h01);
		check("default hk", housekeepingBit, 1'b0);
		@(posedge clock);
		modeSel <= 3'h1;
		repeat (4) @(posedge clock);
		u_bus.runBits(16, 1'b1);
		repeat (4) @(posedge clock);
		check("modem oe", u_bus.oeBv[15:0], 16'hFFFF);
		check("modem byte", lineOut.b1, 8'hA5);
		rstn <= 1'b0;
		repeat (5) @(posedge clock);
		check("rerst ctrl", {ctrlWord, diagWord}, 16'h0000);
		check("rerst oe", {bearerOe, ctrlOe}, 2'h0);
		end_sim();
	end
endmodule : tdm_port_channel_mapper_test
`default_nettype wire
